// file: dv/dmt_cpu_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// CPU side of the register bus
// ------------------------------------------------------------
module dmt_cpu_model (
    // Clock
    input  wire logic        clk_sys,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rdData;
    logic        rdErr;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // Slave may stall, so no wait count is assumed; the bench watchdog cuts a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data lines carry a changing pattern, not the old value
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : dmt_cpu_model

// file: dv/dmt_timer_bench.sv
`timescale 1ns/1ps

module dmt_timer_bench;
    logic        clk_sys, rst, ce, watchTap;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        toggleOutHi, toggleOutLo, irqHi, irqLo;
    int          errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          seed = 2;
    int          t0, n, divs[8];
    logic [15:0] vals[$];
    logic [15:0] v;

    // ------------------------------------------------------------
    // Clock, watch tap, instances
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Watch tap toggles every 5 cycles: one count per 40 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc % 5 == 4) watchTap <= ~watchTap;
    end

    dmt_cpu_model cpu (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                       .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dmt_timer dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
                   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                   .watchTap(watchTap), .toggleOutHi(toggleOutHi), .toggleOutLo(toggleOutLo),
                   .irqHi(irqHi), .irqLo(irqLo));

    // ------------------------------------------------------------
    // Checks and bus helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
        check_count++;
        if (sn !== ex) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, sn);
        end
    endtask : chk

    task automatic rng(input string nm, input int lo, input int hi, input logic [7:0] sn);
        check_count++;
        if ($isunknown(sn) || sn < lo || sn > hi) begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %h", nm, lo, hi, sn);
        end
    endtask : rng

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu.xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
        cpu.xfer(1'b0, a, 8'h00);
        chk(nm, ex, cpu.rdData[7:0]);
    endtask : rd

    task automatic end_sim;
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        watchTap = 1'b0;
        divs = '{0, 0, 0, 0, 32, 16, 4, 40};
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values, 16-bit reads go hi then lo
        rd(dmt_pkg::ADDR_CNT_HI, 8'h00, "cnt_hi");
        rd(dmt_pkg::ADDR_CNT_LO, 8'h00, "cnt_lo");
        rd(dmt_pkg::ADDR_CMP_HI, 8'hff, "cmp_hi");
        rd(dmt_pkg::ADDR_CMP_LO, 8'hff, "cmp_lo");
        rd(dmt_pkg::ADDR_CTRL, 8'h00, "ctrl");
        rd(8'h20, 8'h00, "unmapped");
        chk("pslverr", 8'h01, {7'h00, cpu.rdErr});
        // Every low clock select code in 8-bit mode
        for (int c = 0; c < 8; c++) begin
            wr(dmt_pkg::ADDR_CTRL, {5'b01000, c[2:0]});
            wr(dmt_pkg::ADDR_CNT_LO, 8'h00);
            t0 = cyc;
            repeat (100) @(posedge clk_sys);
            cpu.xfer(1'b0, dmt_pkg::ADDR_CNT_LO, 8'h00);
            n = (divs[c] == 0) ? 0 : (cyc - t0) / divs[c];
            rng("cnt_lo rate", (n > 0) ? n - 1 : 0, (n > 0) ? n + 1 : 0, cpu.rdData[7:0]);
        end
        // Low half match: clear, flag, request, toggle from high level
        v = 16'(4 + ($unsigned($random(seed)) % 16));
        wr(dmt_pkg::ADDR_CTRL_STS, 8'h01);
        wr(dmt_pkg::ADDR_IRQ_EN, 8'h03);
        wr(dmt_pkg::ADDR_CMP_LO, v[7:0]);
        // Counter starts from zero before the count runs, so no match can precede the level check
        wr(dmt_pkg::ADDR_CNT_LO, 8'h00);
        wr(dmt_pkg::ADDR_CTRL, 8'h4e);
        repeat (2) @(posedge clk_sys);
        chk("toggleOutLo init", 8'h01, {7'h00, toggleOutLo});
        for (int i = 0; i < 200 && toggleOutLo !== 1'b0; i++) @(posedge clk_sys);
        chk("toggleOutLo", 8'h00, {7'h00, toggleOutLo});
        repeat (2) @(posedge clk_sys);
        chk("irqLo", 8'h01, {7'h00, irqLo});
        wr(dmt_pkg::ADDR_CTRL, 8'h40);
        cpu.xfer(1'b0, dmt_pkg::ADDR_CNT_LO, 8'h00);
        rng("cnt_lo cleared", 0, v[7:0], cpu.rdData[7:0]);
        rd(dmt_pkg::ADDR_CTRL_STS, 8'h05, "sts lo match");
        rd(dmt_pkg::ADDR_IRQ_REQ, 8'h01, "irq req lo");
        // High half wrap in 8-bit mode, then the read-before-clear rule
        wr(dmt_pkg::ADDR_CTRL, 8'h60);
        wr(dmt_pkg::ADDR_CTRL_STS, 8'h20);
        wr(dmt_pkg::ADDR_CNT_HI, 8'hfe);
        repeat (20) @(posedge clk_sys);
        chk("toggleOutHi", 8'h01, {7'h00, toggleOutHi});
        wr(dmt_pkg::ADDR_CTRL, 8'h00);
        wr(dmt_pkg::ADDR_CTRL_STS, 8'h20);
        rd(dmt_pkg::ADDR_CTRL_STS, 8'he0, "sts hi wrap");
        rd(dmt_pkg::ADDR_IRQ_REQ, 8'h03, "irq req both");
        chk("irqHi", 8'h01, {7'h00, irqHi});
        wr(dmt_pkg::ADDR_CTRL_STS, 8'h00);
        rd(dmt_pkg::ADDR_CTRL_STS, 8'h00, "sts cleared");
        wr(dmt_pkg::ADDR_IRQ_REQ, 8'h00);
        rd(dmt_pkg::ADDR_IRQ_REQ, 8'h00, "irq req cleared");
        // 16-bit readback through the staging latch, model kept in a queue
        repeat (3) begin
            v = 16'($random(seed));
            vals.push_back(v);
            wr(dmt_pkg::ADDR_CMP_HI, v[15:8]);
            wr(dmt_pkg::ADDR_CMP_LO, v[7:0]);
            wr(dmt_pkg::ADDR_CNT_HI, ~v[15:8]);
            wr(dmt_pkg::ADDR_CNT_LO, ~v[7:0]);
        end
        repeat (3) begin
            v = vals.pop_front();
        end
        rd(dmt_pkg::ADDR_CMP_HI, v[15:8], "cmp16 hi");
        rd(dmt_pkg::ADDR_CMP_LO, v[7:0], "cmp16 lo");
        rd(dmt_pkg::ADDR_CNT_HI, ~v[15:8], "cnt16 hi");
        rd(dmt_pkg::ADDR_CNT_LO, ~v[7:0], "cnt16 lo");
        // 16-bit wrap then match at 0001, cascade from low byte
        wr(dmt_pkg::ADDR_CMP_HI, 8'h00);
        wr(dmt_pkg::ADDR_CMP_LO, 8'h01);
        wr(dmt_pkg::ADDR_CNT_HI, 8'hff);
        wr(dmt_pkg::ADDR_CNT_LO, 8'hfe);
        wr(dmt_pkg::ADDR_CTRL_STS, 8'h20);
        wr(dmt_pkg::ADDR_CTRL, 8'h86);
        repeat (2) @(posedge clk_sys);
        chk("toggleOutHi init", 8'h01, {7'h00, toggleOutHi});
        repeat (30) @(posedge clk_sys);
        chk("toggleOutHi 16", 8'h00, {7'h00, toggleOutHi});
        chk("irqHi 16", 8'h01, {7'h00, irqHi});
        wr(dmt_pkg::ADDR_CTRL, 8'h00);
        rd(dmt_pkg::ADDR_CTRL_STS, 8'he0, "sts 16");
        rd(dmt_pkg::ADDR_CNT_HI, 8'h00, "cnt16 hi run");
        end_sim();
    end
endmodule : dmt_timer_bench

// file: verilog/dmt_pkg.sv
package dmt_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CNT_HI   = 8'h00;
    localparam logic [7:0] ADDR_CNT_LO   = 8'h04;
    localparam logic [7:0] ADDR_CMP_HI   = 8'h08;
    localparam logic [7:0] ADDR_CMP_LO   = 8'h0c;
    localparam logic [7:0] ADDR_CTRL     = 8'h10;
    localparam logic [7:0] ADDR_CTRL_STS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_REQ  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h1c;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CNT_RESET  = 8'h00;
    localparam logic [7:0] CMP_RESET  = 8'hff;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_MAX   = 8'hff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STS_OVF_HI  = 7;
    localparam int STS_CMF_HI  = 6;
    localparam int STS_OVIE_HI = 5;
    localparam int STS_CCLR_HI = 4;
    localparam int STS_OVF_LO  = 3;
    localparam int STS_CMF_LO  = 2;
    localparam int STS_OVIE_LO = 1;
    localparam int STS_CCLR_LO = 0;
    localparam int IRQ_BIT_HI  = 1;
    localparam int IRQ_BIT_LO  = 0;

    // ------------------------------------------------------------
    // Clock select codes and prescaler taps
    // ------------------------------------------------------------
    localparam logic [2:0] CKS_STOP    = 3'h0;
    localparam logic [2:0] CKS_DIV32   = 3'h4;
    localparam logic [2:0] CKS_DIV16   = 3'h5;
    localparam logic [2:0] CKS_DIV4    = 3'h6;
    localparam logic [2:0] CKS_WATCH4  = 3'h7;
    localparam int         PRE_WIDTH   = 5;
    localparam logic [4:0] PRE_MASK32  = 5'h1f;
    localparam logic [4:0] PRE_MASK16  = 5'h0f;
    localparam logic [4:0] PRE_MASK4   = 5'h03;
    localparam int         WATCH_DIV   = 4;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       tolHi;
        logic [2:0] cksHi;
        logic       tolLo;
        logic [2:0] cksLo;
    } dmt_ctrl_s;

endpackage : dmt_pkg

// file: verilog/dmt_timer.sv
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// Operation
// R1: Two cascaded 8-bit counters form one 16-bit counter, or run apart.
// R2: Counter bytes are CPU read/write; 16-bit mode goes through staging latch.
// R3: Compare bytes are CPU read/write; 16-bit mode goes through staging latch.
// R4: Reset loads both counter bytes with zero.
// R5: Reset loads both compare bytes with all ones.
// R6: High select top bit zero gives 16-bit counting from low select.
// R7: 16-bit mode clears whole counter on match only if high clear set.
// R8: 16-bit wrap sets high overflow flag, request if enabled, interrupt if enabled.
// R9: High select top bit one runs bytes apart, each by own select.
// R10: 8-bit mode clears each byte on its match if its clear bit set.
// R11: 8-bit wrap of each byte sets own flag and gated request.
// R12: 16-bit mode compares full words; equality sets high match flag and request.
// R13: 8-bit mode compares each byte pair; match sets own flag and request.
// R14: 16-bit mode toggles high output on match from programmed level.
// R15: 8-bit mode toggles each output on own match from programmed level.
// R16: Control register is write-only, zero at reset, levels at bits 7 and 3.
// R17: High select decodes cascade, prohibited, divide by 32/16/4 and watch/4.
// R18: Low select decodes stop, prohibited, divide by 32/16/4 and watch/4.
// R19: Status flags clear only by writing zero after reading them as one.
// R20: Selected taps become single-cycle enables; watch tap synchronised first.
module dmt_timer (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Watch clock prescaler tap, asynchronous
    input  wire logic        watchTap,
    // Toggle pins and interrupts to the CPU
    output logic             toggleOutHi,
    output logic             toggleOutLo,
    output logic             irqHi,
    output logic             irqLo
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dmt_pkg::dmt_ctrl_s ctrl_q;
    logic [7:0]  cntHi_q, cntLo_q, cmpHi_q, cmpLo_q, stage_q;
    logic [7:0]  ctlSts_q;
    logic [3:0]  flag_q, seen_q, flagSet, flagClr;
    logic [1:0]  irqReq_q, irqEn_q;
    logic [4:0]  preDiv_q;
    logic [2:0]  watchSync_q;
    logic [1:0]  watchDiv_q;
    logic        eqHiPrev_q, eqLoPrev_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q, togHi_q, togLo_q, irqHi_q, irqLo_q;
    logic        split, tickLo, tickHi, watchTick, tick32, tick16, tick4;
    logic        eqHi, eqLo, matchHi, matchLo, clrHi, clrLo, ovHi, ovLo;
    logic        access, wrEn, rdEn, mapped;
    logic [7:0]  wByte, rdByte;

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign toggleOutHi = togHi_q;
    assign toggleOutLo = togLo_q;
    assign irqHi       = irqHi_q;
    assign irqLo       = irqLo_q;

    // ------------------------------------------------------------
    // Prescaler taps
    // ------------------------------------------------------------
    function automatic logic tapSel(input logic [2:0] sel, input logic t32, input logic t16,
                                    input logic t4, input logic tw);
        case (sel)
            dmt_pkg::CKS_DIV32:  tapSel = t32;
            dmt_pkg::CKS_DIV16:  tapSel = t16;
            dmt_pkg::CKS_DIV4:   tapSel = t4;
            dmt_pkg::CKS_WATCH4: tapSel = tw;
            default:             tapSel = 1'b0; // Stop and prohibited codes never count
        endcase
    endfunction : tapSel

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            preDiv_q <= '0;
        end else if (ce) begin
            preDiv_q <= preDiv_q + 5'h01;
        end
    end

    // Watch tap crosses into the system domain before its edges are counted
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            watchSync_q <= '0;
            watchDiv_q  <= '0;
        end else if (ce) begin
            watchSync_q <= {watchSync_q[1:0], watchTap}; // R20
            if (watchSync_q[1] && !watchSync_q[2]) begin
                watchDiv_q <= watchDiv_q + 2'h1;
            end
        end
    end

    assign tick32    = (preDiv_q & dmt_pkg::PRE_MASK32) == dmt_pkg::PRE_MASK32; // R20
    assign tick16    = (preDiv_q & dmt_pkg::PRE_MASK16) == dmt_pkg::PRE_MASK16;
    assign tick4     = (preDiv_q & dmt_pkg::PRE_MASK4) == dmt_pkg::PRE_MASK4;
    assign watchTick = watchSync_q[1] && !watchSync_q[2] && (watchDiv_q == 2'(dmt_pkg::WATCH_DIV - 1));

    // ------------------------------------------------------------
    // Mode, compare and count events
    // ------------------------------------------------------------
    assign split  = ctrl_q.cksHi[2]; // R6 R9
    assign tickLo = tapSel(ctrl_q.cksLo, tick32, tick16, tick4, watchTick); // R18
    // Cascade on low byte wrap in 16-bit mode; own tap otherwise
    assign tickHi = split ? tapSel(ctrl_q.cksHi, tick32, tick16, tick4, watchTick) // R17
                          : (tickLo && cntLo_q == dmt_pkg::BYTE_MAX); // R1
    assign eqLo   = split && (cntLo_q == cmpLo_q); // R13
    assign eqHi   = split ? (cntHi_q == cmpHi_q)
                          : ({cntHi_q, cntLo_q} == {cmpHi_q, cmpLo_q}); // R12
    // A match is the cycle the equality begins, so a stalled count flags once
    assign matchHi = eqHi && !eqHiPrev_q;
    assign matchLo = eqLo && !eqLoPrev_q;
    // Clear replaces the next count step once the counter sits on the compare value
    assign clrHi  = eqHi && ctlSts_q[dmt_pkg::STS_CCLR_HI] && (split ? tickHi : tickLo); // R7 R10
    assign clrLo  = split ? (eqLo && ctlSts_q[dmt_pkg::STS_CCLR_LO] && tickLo) : clrHi; // R10
    assign ovHi   = tickHi && !clrHi && cntHi_q == dmt_pkg::BYTE_MAX; // R8 R11
    assign ovLo   = split && tickLo && !clrLo && cntLo_q == dmt_pkg::BYTE_MAX; // R11

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            eqHiPrev_q <= 1'b0;
            eqLoPrev_q <= 1'b0;
        end else if (ce) begin
            eqHiPrev_q <= eqHi;
            eqLoPrev_q <= eqLo;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign access = psel && penable && pready_q;
    assign wrEn   = access && pwrite;
    assign rdEn   = access && !pwrite;
    assign wByte  = pwdata[7:0];
    assign mapped = paddr[1:0] == 2'h0 && paddr <= dmt_pkg::ADDR_IRQ_EN;

    always_comb begin
        case (paddr)
            dmt_pkg::ADDR_CNT_HI:   rdByte = cntHi_q;
            dmt_pkg::ADDR_CNT_LO:   rdByte = split ? cntLo_q : stage_q; // R2
            dmt_pkg::ADDR_CMP_HI:   rdByte = cmpHi_q;
            dmt_pkg::ADDR_CMP_LO:   rdByte = split ? cmpLo_q : stage_q; // R3
            dmt_pkg::ADDR_CTRL_STS: rdByte = {flag_q[3:2], ctlSts_q[5:4], flag_q[1:0], ctlSts_q[1:0]};
            dmt_pkg::ADDR_IRQ_REQ:  rdByte = {6'h00, irqReq_q};
            dmt_pkg::ADDR_IRQ_EN:   rdByte = {6'h00, irqEn_q};
            default:                rdByte = 8'h00; // Control register is write-only
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (ce) begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            if (psel && penable && !pready_q) begin
                prdata_q <= {24'h000000, rdByte};
            end
        end
    end

    // Staging latch: high byte access moves the pair through it in 16-bit mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage_q <= 8'h00;
        end else if (ce && !split) begin
            if (wrEn && (paddr == dmt_pkg::ADDR_CNT_HI || paddr == dmt_pkg::ADDR_CMP_HI)) begin
                stage_q <= wByte; // R2 R3
            end else if (rdEn && paddr == dmt_pkg::ADDR_CNT_HI) begin
                stage_q <= cntLo_q; // R2
            end else if (rdEn && paddr == dmt_pkg::ADDR_CMP_HI) begin
                stage_q <= cmpLo_q; // R3
            end
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cntHi_q <= dmt_pkg::CNT_RESET; // R4
            cntLo_q <= dmt_pkg::CNT_RESET; // R4
        end else if (ce) begin
            // A CPU write beats a count step in the same cycle
            if (wrEn && paddr == dmt_pkg::ADDR_CNT_LO) begin
                cntLo_q <= wByte;
                if (!split) begin
                    cntHi_q <= stage_q; // R2
                end
            end else if (wrEn && paddr == dmt_pkg::ADDR_CNT_HI && split) begin
                cntHi_q <= wByte; // R2
            end else begin
                if (clrLo) begin
                    cntLo_q <= dmt_pkg::CNT_RESET;
                end else if (tickLo) begin
                    cntLo_q <= cntLo_q + 8'h01;
                end
                if (clrHi) begin
                    cntHi_q <= dmt_pkg::CNT_RESET;
                end else if (tickHi) begin
                    cntHi_q <= cntHi_q + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Compare, control and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmpHi_q <= dmt_pkg::CMP_RESET; // R5
            cmpLo_q <= dmt_pkg::CMP_RESET; // R5
        end else if (ce && wrEn) begin
            if (paddr == dmt_pkg::ADDR_CMP_LO) begin
                cmpLo_q <= wByte;
                if (!split) begin
                    cmpHi_q <= stage_q; // R3
                end
            end else if (paddr == dmt_pkg::ADDR_CMP_HI && split) begin
                cmpHi_q <= wByte; // R3
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q   <= dmt_pkg::CTRL_RESET; // R16
            ctlSts_q <= 8'h00;
            irqEn_q  <= 2'h0;
        end else if (ce && wrEn) begin
            if (paddr == dmt_pkg::ADDR_CTRL) begin
                ctrl_q <= wByte; // R16
            end
            if (paddr == dmt_pkg::ADDR_CTRL_STS) begin
                ctlSts_q <= wByte;
            end
            if (paddr == dmt_pkg::ADDR_IRQ_EN) begin
                irqEn_q <= wByte[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags: 3 overflow hi, 2 match hi, 1 overflow lo, 0 match lo
    // ------------------------------------------------------------
    assign flagSet = {ovHi, matchHi, ovLo, matchLo};

    for (genvar i = 0; i < 4; i++) begin : g_flag
        localparam int BitPos = (i >= 2) ? i + 4 : i + 2;
        // Clearing needs a prior read of one; a new event in that cycle still wins
        assign flagClr[i] = wrEn && paddr == dmt_pkg::ADDR_CTRL_STS && !wByte[BitPos] && seen_q[i];
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                flag_q[i] <= 1'b0;
                seen_q[i] <= 1'b0;
            end else if (ce) begin
                if (flagSet[i]) begin
                    flag_q[i] <= 1'b1; // R8 R11 R12 R13
                end else if (flagClr[i]) begin
                    flag_q[i] <= 1'b0; // R19
                end
                if (rdEn && paddr == dmt_pkg::ADDR_CTRL_STS && flag_q[i]) begin
                    seen_q[i] <= 1'b1; // R19
                end else if (flagClr[i] || !flag_q[i]) begin
                    seen_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt requests and toggle outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqReq_q <= 2'h0;
            irqHi_q  <= 1'b0;
            irqLo_q  <= 1'b0;
        end else if (ce) begin
            for (int b = 0; b < 2; b++) begin
                if ((b == dmt_pkg::IRQ_BIT_HI) ? (matchHi || (ovHi && ctlSts_q[dmt_pkg::STS_OVIE_HI]))
                                               : (matchLo || (ovLo && ctlSts_q[dmt_pkg::STS_OVIE_LO]))) begin
                    irqReq_q[b] <= 1'b1; // R8 R11 R12 R13
                end else if (wrEn && paddr == dmt_pkg::ADDR_IRQ_REQ && !wByte[b]) begin
                    irqReq_q[b] <= 1'b0;
                end
            end
            irqHi_q <= irqReq_q[dmt_pkg::IRQ_BIT_HI] && irqEn_q[dmt_pkg::IRQ_BIT_HI];
            irqLo_q <= irqReq_q[dmt_pkg::IRQ_BIT_LO] && irqEn_q[dmt_pkg::IRQ_BIT_LO];
        end
    end

    // Writing the control register reloads the pin levels
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            togHi_q <= 1'b0;
            togLo_q <= 1'b0;
        end else if (ce) begin
            if (wrEn && paddr == dmt_pkg::ADDR_CTRL) begin
                togHi_q <= wByte[7]; // R14 R15
                togLo_q <= wByte[3]; // R15
            end else begin
                togHi_q <= togHi_q ^ matchHi; // R14 R15
                togLo_q <= togLo_q ^ matchLo; // R15
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_setup;
        psel && penable && !pready_q && ce;
    endsequence
    sequence s_done;
        ##1 pready_q;
    endsequence

    apb_answer_a: assert property (s_setup |-> s_done) // R2
        else $error("APB access not answered in one wait state");
    cnt_reset_a: assert property ($past(rst) |-> cntHi_q == 8'h00 && cntLo_q == 8'h00) // R4
        else $error("Counter not zero after reset");
    cmp_reset_a: assert property ($past(rst) |-> cmpHi_q == 8'hff && cmpLo_q == 8'hff) // R5
        else $error("Compare not all ones after reset");
    lo_stop_a: assert property (ce && ctrl_q.cksLo == 3'h0 && !wrEn |=> $stable(cntLo_q)) // R18
        else $error("Low counter moved while stopped");
    match_flag_a: assert property (ce && matchHi |=> flag_q[2] && irqReq_q[1]) // R12
        else $error("Match did not set flag and request");
    ovf_flag_a: assert property (ce && ovHi && !split |=> flag_q[3] && cntHi_q == 8'h00) // R8
        else $error("16-bit wrap did not set overflow");
    toggle_out_a: assert property (ce && matchHi && !wrEn |=> togHi_q != $past(togHi_q)) // R14
        else $error("High pin did not toggle on match");
    clear_match_a: assert property (ce && clrHi && !wrEn && !split |=> {cntHi_q, cntLo_q} == 16'h0000) // R7
        else $error("Counter not cleared on match");
    flag_hold_a: assert property (ce && flag_q[0] && !seen_q[0] && !flagSet[0] |=> flag_q[0]) // R19
        else $error("Flag cleared without prior read");

endmodule : dmt_timer
